// >>> design/bus_node_consts.svh
// Constants of the bus node port register set: offsets, fields, codes, status values.
// Assumes byte addresses on the register port and one 32-bit word per register.
`ifndef BUS_NODE_CONSTS_SVH
`define BUS_NODE_CONSTS_SVH

// Register byte offsets
`define OFS_FAIL_ADDR 12'h008
`define OFS_MAILBOX 12'h010
`define OFS_FAIL_EXT 12'h02c
`define OFS_PD_FIRST 12'h100
`define OFS_PD_SECOND 12'h104
`define OFS_PORT_STATUS 12'h108
`define OFS_PORT_INIT 12'h110

// Command/address word fields
`define CA_MORE_BIT 59
`define CA_CMD_MSB 63
`define CA_CMD_LSB 60
`define CA_EXT_MSB 57
`define CA_EXT_LSB 48
`define CA_MASK_MSB 47
`define CA_MASK_LSB 32
`define CA_LEN_MSB 31
`define CA_LEN_LSB 30
`define CA_A29_BIT 29

// Mailbox fields
`define MB_OUT_BUSY 31
`define MB_OUT_ID_MSB 27
`define MB_OUT_ID_LSB 24
`define MB_OUT_CHR_MSB 23
`define MB_OUT_CHR_LSB 16
`define MB_IN_BUSY 15
`define MB_WMASK 32'h8fff8fff

// Mailbox special codes
`define MB_MAC_LO 32'hffffffff
`define MB_MAC_HI 32'hfffffffe
`define MB_SER_0 32'hfffffffd
`define MB_SER_1 32'hfffffffc
`define MB_SER_2 32'hfffffffb
`define MB_INVAL 32'hfffffffa
`define MB_ERASE 32'hfffffff9
`define MB_HIST_HI 32'hfffffff8
`define MB_HIST_LO 32'hfffffef9
`define MB_HIST_BIAS 32'h00000007

// Port status values
`define PS_STATE_RESETTING 8'h00
`define PS_STATE_UNINIT 8'h01
`define PS_STATE_INIT 8'h02
`define PS_QUAL_OK 24'h000000
`define PS_QUAL_SELFTEST 24'h000001
`define PS_QUAL_HALT 24'h00000d

`endif

// >>> design/bus_node_pkg.sv
// Types of the bus node port register set.
// Assumes the constants header is included by the modules that need numbers.
package bus_node_pkg;

  // Port state, one-hot
  typedef enum logic [2:0] {
    ST_RESETTING = 3'b001,
    ST_UNINIT = 3'b010,
    ST_INIT = 3'b100
  } port_state_type;

endpackage : bus_node_pkg

// >>> design/bus_node_port_register_set.sv
// Bus-visible register set of a network adapter node: failing transaction log,
// character mailbox, port data registers and port status.
// Assumes all inputs come from logic on clk_i; the host register port is one
// access per cycle with read data returned one cycle later.
//
// Behaviour
// - Bit 59 of an issued command/address word is set only while more-enable is high.
// - Failing length logs data 31:30 per issued cycle, freezes on failure, releases.
// - Failing address logs data 29:0 per issued cycle, freezes on failure, releases.
// - 40-bit mode puts address 38:29 in 57:48, bit 39 in 29.
// - Node sets outbound busy with a character; host clears it after reading.
// - Node writes its slot identifier to 27:24 and character to 23:16.
// - Inbound busy marks an unconsumed character; node clears it after reading.
// - Codes all-ones and next lower return MAC bytes 0-3 then 4-5.
// - Three following codes return serial number bytes 0-3, 4-7, 8-11.
// - Invalidate code invalidates firmware memory; mailbox reads zero when done.
// - Erase code clears error history; mailbox reads zero when done.
// - Negated offsets minus 8 to minus 107 hex read history longwords 0-255.
// - Failing command logs data 63:60 with the same freeze and release.
// - Extension address logs data 57:48 or DMA address 38:29, same rules.
// - Failing mask logs data 47:32 or DMA write mask.
// - Base address transfer: first holds bits 31:0, second bits 39:32.
// - After power-up, reset or restart node loads MAC into port data registers.
// - Fatal error loads first register; second keeps ring count, also for address data.
// - Status shows self-test fail, halt in progress and initialized exactly.
// - Any write to the init trigger starts initialization; data ignored.
`timescale 1ns/1ps
`include "bus_node_consts.svh"

module bus_node_port_register_set
  import bus_node_pkg::*;
#(
  parameter int HIST_DEPTH = 256
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Host register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Command/address cycle issue
  input wire logic ca_issue_i,
  input wire logic [3:0] ca_cmd_i,
  input wire logic [1:0] ca_len_i,
  input wire logic [15:0] ca_mask_i,
  input wire logic [39:0] ca_addr_i,
  input wire logic addr40_i,
  input wire logic more_req_i,
  input wire logic more_enable_i,
  output logic ca_valid_o,
  output logic [63:0] ca_data_o,
  input wire logic retries_failed_i,
  input wire logic error_clear_i,
  input wire logic dma_log_i,
  input wire logic [9:0] dma_addr_hi_i,
  input wire logic [15:0] dma_mask_i,
  // Node side of the mailbox
  input wire logic [3:0] node_id_i,
  input wire logic char_out_valid_i,
  input wire logic [7:0] char_out_i,
  input wire logic char_in_ack_i,
  output logic char_in_busy_o,
  output logic [7:0] char_in_o,
  output logic [3:0] char_in_id_o,
  // Identity and history storage
  input wire logic [47:0] mac_addr_i,
  input wire logic [95:0] serial_i,
  input wire logic hist_wr_i,
  input wire logic [7:0] hist_idx_i,
  input wire logic [31:0] hist_data_i,
  output logic nvm_invalidate_o,
  input wire logic nvm_done_i,
  // Port control and status events
  input wire logic reset_start_i,
  input wire logic boot_done_i,
  input wire logic selftest_fail_i,
  input wire logic init_ok_i,
  input wire logic fatal_i,
  input wire logic [23:0] fatal_qual_i,
  input wire logic [31:0] fatal_data_i,
  input wire logic fatal_data_is_addr_i,
  output logic init_start_o,
  output logic [31:0] pd_first_o,
  output logic [31:0] pd_second_o
);

  // ==========================================================================
  // Register port decode
  // ==========================================================================
  logic wr_mbox, wr_pd1, wr_pd2, wr_init;
  assign wr_mbox = reg_wr_i && (reg_addr_i == `OFS_MAILBOX);
  assign wr_pd1 = reg_wr_i && (reg_addr_i == `OFS_PD_FIRST);
  assign wr_pd2 = reg_wr_i && (reg_addr_i == `OFS_PD_SECOND);
  assign wr_init = reg_wr_i && (reg_addr_i == `OFS_PORT_INIT);

  // ==========================================================================
  // Command/address word build and failing transaction log
  // ==========================================================================
  logic [63:0] ca_word;
  logic [9:0] ext_addr;
  logic a29_bit;
  logic ca_valid_reg;
  logic [63:0] ca_data_reg;
  logic lock_reg, lock_next;
  logic [31:0] fail_addr_reg, fail_addr_next;
  logic [31:0] fail_ext_reg, fail_ext_next;

  // Address packing for 30-bit or 40-bit systems
  assign ext_addr = addr40_i ? ca_addr_i[38:29] : 10'h000;
  assign a29_bit = addr40_i ? ca_addr_i[39] : ca_addr_i[29];
  assign ca_word = {ca_cmd_i, more_req_i && more_enable_i, 1'b0, ext_addr, ca_mask_i,
                    ca_len_i, a29_bit, ca_addr_i[28:0]};

  // Freeze on final retry failure; a failure in the clearing cycle keeps the lock
  assign lock_next = retries_failed_i ? 1'b1 : (error_clear_i ? 1'b0 : lock_reg);
  // Fields load while unlocked
  assign fail_addr_next = (ca_issue_i && !lock_reg) ? ca_word[31:0] : fail_addr_reg;
  assign fail_ext_next = lock_reg ? fail_ext_reg :
    ca_issue_i ? {ca_word[`CA_CMD_MSB:`CA_CMD_LSB], 2'b00, ca_word[`CA_EXT_MSB:`CA_EXT_LSB],
                  ca_word[`CA_MASK_MSB:`CA_MASK_LSB]} :
    dma_log_i ? {fail_ext_reg[31:26], dma_addr_hi_i, dma_mask_i} : fail_ext_reg;

  // Issue and log registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ca_valid_reg <= 1'b0;
      ca_data_reg <= 64'h0;
      lock_reg <= 1'b0;
      fail_addr_reg <= 32'h0;
      fail_ext_reg <= 32'h0;
    end else begin
      ca_valid_reg <= ca_issue_i;
      ca_data_reg <= ca_issue_i ? ca_word : ca_data_reg;
      lock_reg <= lock_next;
      fail_addr_reg <= fail_addr_next;
      fail_ext_reg <= fail_ext_next;
    end
  end

  // ==========================================================================
  // History storage with erase walker
  // ==========================================================================
  logic [31:0] hist_mem [HIST_DEPTH];
  logic erase_busy_reg, erase_busy_next;
  logic [7:0] erase_idx_reg;
  logic [7:0] hist_rd_idx;
  logic [31:0] hist_code_ofs;

  assign hist_code_ofs = ~reg_wdata_i - `MB_HIST_BIAS;
  assign hist_rd_idx = hist_code_ofs[7:0];
  assign erase_busy_next = (wr_mbox && reg_wdata_i == `MB_ERASE) ? 1'b1 :
    (erase_busy_reg && erase_idx_reg == 8'hff) ? 1'b0 : erase_busy_reg;

  // Erase zeroes one entry per cycle and takes precedence over node writes
  always_ff @(posedge clk_i) begin
    if (erase_busy_reg) begin
      hist_mem[erase_idx_reg] <= 32'h0;
    end else if (hist_wr_i) begin
      hist_mem[hist_idx_i] <= hist_data_i;
    end
  end

  // Erase walker
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      erase_busy_reg <= 1'b0;
      erase_idx_reg <= 8'h00;
    end else begin
      erase_busy_reg <= erase_busy_next;
      erase_idx_reg <= erase_busy_reg ? erase_idx_reg + 8'h01 : 8'h00;
    end
  end

  // ==========================================================================
  // Character mailbox
  // ==========================================================================
  logic [31:0] mbox_reg, mbox_next, mbox_host;
  logic inval_busy_reg;
  logic is_hist;

  assign is_hist = (reg_wdata_i >= `MB_HIST_LO) && (reg_wdata_i <= `MB_HIST_HI);
  // Host write: special codes answer, anything else is stored
  assign mbox_host =
    (reg_wdata_i == `MB_MAC_LO) ? mac_addr_i[31:0] :
    (reg_wdata_i == `MB_MAC_HI) ? {16'h0000, mac_addr_i[47:32]} :
    (reg_wdata_i == `MB_SER_0) ? serial_i[31:0] :
    (reg_wdata_i == `MB_SER_1) ? serial_i[63:32] :
    (reg_wdata_i == `MB_SER_2) ? serial_i[95:64] :
    (reg_wdata_i == `MB_INVAL) ? reg_wdata_i :
    (reg_wdata_i == `MB_ERASE) ? reg_wdata_i :
    is_hist ? hist_mem[hist_rd_idx] :
    (reg_wdata_i & `MB_WMASK);

  // Node writes go on top; outbound busy set wins over any clear, inbound busy set over the node acknowledge
  always_comb begin
    mbox_next = wr_mbox ? mbox_host : mbox_reg;
    if (inval_busy_reg && nvm_done_i) begin
      mbox_next = 32'h0;
    end
    if (erase_busy_reg && erase_idx_reg == 8'hff) begin
      mbox_next = 32'h0;
    end
    if (char_in_ack_i && !wr_mbox) begin
      mbox_next[`MB_IN_BUSY] = 1'b0;
    end
    if (char_out_valid_i) begin
      mbox_next[`MB_OUT_BUSY] = 1'b1;
      mbox_next[`MB_OUT_ID_MSB:`MB_OUT_ID_LSB] = node_id_i;
      mbox_next[`MB_OUT_CHR_MSB:`MB_OUT_CHR_LSB] = char_out_i;
    end
  end

  // Mailbox and invalidate handshake
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mbox_reg <= 32'h0;
      inval_busy_reg <= 1'b0;
    end else begin
      mbox_reg <= mbox_next;
      inval_busy_reg <= (wr_mbox && reg_wdata_i == `MB_INVAL) ? 1'b1 :
                        (nvm_done_i ? 1'b0 : inval_busy_reg);
    end
  end

  // ==========================================================================
  // Port data registers
  // ==========================================================================
  logic [31:0] pd1_reg, pd1_next, pd2_reg, pd2_next;

  // Node loads win over host writes in the same cycle
  assign pd1_next = boot_done_i ? mac_addr_i[31:0] :
    fatal_i ? fatal_data_i :
    wr_pd1 ? reg_wdata_i : pd1_reg;
  assign pd2_next = boot_done_i ? {16'h0000, mac_addr_i[47:32]} :
    (fatal_i && fatal_data_is_addr_i) ? pd2_reg :
    wr_pd2 ? reg_wdata_i : pd2_reg;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pd1_reg <= 32'h0;
      pd2_reg <= 32'h0;
    end else begin
      pd1_reg <= pd1_next;
      pd2_reg <= pd2_next;
    end
  end

  // ==========================================================================
  // Port state and status
  // ==========================================================================
  port_state_type state_reg, state_next;
  logic [23:0] qual_reg, qual_next;
  logic [7:0] state_code;
  logic init_start_reg;

  always_comb begin
    state_next = state_reg;
    qual_next = qual_reg;
    if (reset_start_i) begin
      state_next = ST_RESETTING;
      qual_next = `PS_QUAL_HALT;
    end else if (fatal_i) begin
      state_next = ST_UNINIT;
      qual_next = fatal_qual_i;
    end else if (boot_done_i) begin
      state_next = ST_UNINIT;
      qual_next = selftest_fail_i ? `PS_QUAL_SELFTEST : `PS_QUAL_OK;
    end else if (init_ok_i) begin
      state_next = ST_INIT;
      qual_next = `PS_QUAL_OK;
    end
  end

  // State code for the status word
  always_comb begin
    case (state_reg)
      ST_RESETTING: state_code = `PS_STATE_RESETTING;
      ST_UNINIT: state_code = `PS_STATE_UNINIT;
      ST_INIT: state_code = `PS_STATE_INIT;
      default: state_code = `PS_STATE_RESETTING;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_RESETTING;
      qual_reg <= `PS_QUAL_OK;
      init_start_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      qual_reg <= qual_next;
      init_start_reg <= wr_init;
    end
  end

  // ==========================================================================
  // Read data and outputs
  // ==========================================================================
  logic [31:0] rd_mux, rdata_reg;
  logic rvalid_reg;

  assign rd_mux = (reg_addr_i == `OFS_FAIL_ADDR) ? fail_addr_reg :
    (reg_addr_i == `OFS_MAILBOX) ? mbox_reg :
    (reg_addr_i == `OFS_FAIL_EXT) ? fail_ext_reg :
    (reg_addr_i == `OFS_PD_FIRST) ? pd1_reg :
    (reg_addr_i == `OFS_PD_SECOND) ? pd2_reg :
    (reg_addr_i == `OFS_PORT_STATUS) ? {qual_reg, state_code} : 32'h0;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 32'h0;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= reg_rd_i ? rd_mux : rdata_reg;
      rvalid_reg <= reg_rd_i;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata_o = rdata_reg;
  assign reg_rvalid_o = rvalid_reg;
  assign ca_valid_o = ca_valid_reg;
  assign ca_data_o = ca_data_reg;
  assign char_in_busy_o = mbox_reg[`MB_IN_BUSY];
  assign char_in_o = mbox_reg[7:0];
  assign char_in_id_o = mbox_reg[11:8];
  assign nvm_invalidate_o = inval_busy_reg;
  assign init_start_o = init_start_reg;
  assign pd_first_o = pd1_reg;
  assign pd_second_o = pd2_reg;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence erase_req_s;
    wr_mbox && reg_wdata_i == `MB_ERASE && !char_out_valid_i;
  endsequence

  sequence erase_done_s;
    ##[257:260] (!erase_busy_reg && mbox_reg == 32'h0);
  endsequence

  more_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ca_issue_i && !more_enable_i |=> ca_valid_o && !ca_data_o[`CA_MORE_BIT])
    else $error("more bit driven while disabled");

  addr_capture_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ca_issue_i && !lock_reg |=> fail_addr_reg[29:0] == $past(ca_addr_i[29:0]) || $past(addr40_i))
    else $error("failing address not captured");

  lock_freeze_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    retries_failed_i ##1 (!error_clear_i)[*2] |=> $stable(fail_addr_reg) && $stable(fail_ext_reg))
    else $error("failing log changed while locked");

  cmd_capture_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ca_issue_i && !lock_reg |=> fail_ext_reg[31:28] == $past(ca_cmd_i))
    else $error("failing command not captured");

  out_busy_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    char_out_valid_i |=> mbox_reg[31] && mbox_reg[23:16] == $past(char_out_i))
    else $error("outbound character not posted");

  in_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    char_in_ack_i && !wr_mbox |=> !char_in_busy_o)
    else $error("inbound busy not cleared");

  mac_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_mbox && reg_wdata_i == `MB_MAC_LO && !char_out_valid_i && !char_in_ack_i
    |=> mbox_reg == $past(mac_addr_i[31:0]))
    else $error("MAC low word not returned");

  erase_seq_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    erase_req_s |-> erase_done_s)
    else $error("history erase did not finish");

  init_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_init |=> init_start_o ##1 !init_start_o || $past(wr_init))
    else $error("init trigger not pulsed");

  status_init_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    init_ok_i && !reset_start_i && !fatal_i && !boot_done_i
    ##1 reg_rd_i && reg_addr_i == `OFS_PORT_STATUS && !reset_start_i && !fatal_i && !boot_done_i
    |=> reg_rdata_o == 32'h00000002)
    else $error("initialized status wrong");

  mac_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    boot_done_i |=> pd_first_o == $past(mac_addr_i[31:0]) && pd_second_o[15:0] == $past(mac_addr_i[47:32]))
    else $error("MAC not loaded to port data");

endmodule : bus_node_port_register_set

// >>> sim/bus_node_port_register_set_tb.sv
// Self-checking bench of the bus node port register set.
// Assumes the host model drives the register port; node events come from here.
`timescale 1ns/1ps
`include "bus_node_consts.svh"

module bus_node_port_register_set_tb;
  // ==========================================================
  // Signals
  localparam logic [3:0] NODE_ID = 4'h6;
  localparam logic [47:0] MAC = 48'h1a2b_3c4d_5e6f;
  localparam logic [95:0] SERIAL = 96'hb1b0a9a8_a7a6a5a4_a3a2a1a0;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic reg_wr, reg_rd, reg_rvalid;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [11:0] ev = 12'h000;
  logic [3:0] ca_cmd = 4'h0;
  logic [1:0] ca_len = 2'h0;
  logic [15:0] ca_mask = 16'h0000;
  logic [39:0] ca_addr = 40'h0;
  logic addr40 = 1'b0, more_req = 1'b0, more_en = 1'b0, selftest_fail = 1'b0, fis_addr = 1'b0;
  logic [9:0] dma_hi = 10'h000;
  logic [15:0] dma_mask = 16'h0000;
  logic [7:0] chr = 8'h00, hist_idx = 8'h00;
  logic [31:0] hist_data = 32'h0, fdata = 32'h0, pd1, pd2;
  logic [23:0] fqual = 24'h0;
  logic ca_valid, cib, nvm_inv, init_start;
  logic [63:0] ca_data, e;
  logic [7:0] cin;
  logic [3:0] cid;
  int n_mismatch = 0;
  int num_checks = 0;

  // Clock at 25 MHz
  always #20 clk_i = ~clk_i;

  // ==========================================================
  // Instances
  host_port_driver host (.clk_i(clk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata), .reg_rvalid_i(reg_rvalid));

  bus_node_port_register_set dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid),
    .ca_issue_i(ev[0]), .ca_cmd_i(ca_cmd), .ca_len_i(ca_len), .ca_mask_i(ca_mask), .ca_addr_i(ca_addr),
    .addr40_i(addr40), .more_req_i(more_req), .more_enable_i(more_en), .ca_valid_o(ca_valid),
    .ca_data_o(ca_data), .retries_failed_i(ev[1]), .error_clear_i(ev[2]), .dma_log_i(ev[3]),
    .dma_addr_hi_i(dma_hi), .dma_mask_i(dma_mask), .node_id_i(NODE_ID), .char_out_valid_i(ev[4]),
    .char_out_i(chr), .char_in_ack_i(ev[5]), .char_in_busy_o(cib), .char_in_o(cin), .char_in_id_o(cid),
    .mac_addr_i(MAC), .serial_i(SERIAL), .hist_wr_i(ev[6]), .hist_idx_i(hist_idx), .hist_data_i(hist_data),
    .nvm_invalidate_o(nvm_inv), .nvm_done_i(ev[7]), .reset_start_i(ev[8]), .boot_done_i(ev[9]),
    .selftest_fail_i(selftest_fail), .init_ok_i(ev[10]), .fatal_i(ev[11]), .fatal_qual_i(fqual),
    .fatal_data_i(fdata), .fatal_data_is_addr_i(fis_addr), .init_start_o(init_start), .pd_first_o(pd1),
    .pd_second_o(pd2));

  // ==========================================================
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask : tick

  // One-cycle node event on line i of ev
  task automatic pulse(input int i);
    ev[i] = 1'b1;
    tick(1);
    ev[i] = 1'b0;
  endtask : pulse

  // Port value compare
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Register read compare under a mask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] d;
    host.rd(a, d);
    chk(64'(d & m), 64'(x));
  endtask : rdchk

  // Expected command/address word from the inputs
  function automatic logic [63:0] exp_ca();
    logic [9:0] hi;
    hi = addr40 ? ca_addr[38:29] : 10'h000;
    return {ca_cmd, more_req & more_en, 1'b0, hi, ca_mask, ca_len, addr40 ? ca_addr[39] : ca_addr[29],
      ca_addr[28:0]};
  endfunction : exp_ca

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  // ==========================================================
  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk_i);
    n_mismatch++;
    end_sim();
  end

  // ==========================================================
  // Tests
  initial begin
    tick(16);
    rst_n_i = 1'b1;
    rdchk(`OFS_PORT_STATUS, '1, 32'h0000_0000);
    selftest_fail = 1'b1;
    pulse(9);
    rdchk(`OFS_PORT_STATUS, '1, 32'h0000_0101);
    rdchk(`OFS_PD_FIRST, '1, MAC[31:0]);
    rdchk(`OFS_PD_SECOND, 32'h0000_ffff, {16'h0000, MAC[47:32]});
    pulse(8);
    rdchk(`OFS_PORT_STATUS, '1, 32'h0000_0d00);
    selftest_fail = 1'b0;
    pulse(9);
    rdchk(`OFS_PORT_STATUS, '1, 32'h0000_0001);
    host.wr(`OFS_PORT_INIT, 32'h5a5a_0000);
    chk(64'(init_start), 64'h1);
    pulse(10);
    rdchk(`OFS_PORT_STATUS, '1, 32'h0000_0002);
    $display("test status finished");
    host.wr(`OFS_PD_FIRST, 32'h89ab_cdef);
    host.wr(`OFS_PD_SECOND, 32'h0000_0042);
    rdchk(`OFS_PD_FIRST, '1, 32'h89ab_cdef);
    rdchk(`OFS_PD_SECOND, '1, 32'h0000_0042);
    host.wr(`OFS_PD_SECOND, 32'h0000_001f);
    fqual = 24'h00000b;
    fdata = 32'h0001_2340;
    pulse(11);
    chk(64'(pd1), 64'(fdata));
    chk(64'(pd2), 64'h1f);
    rdchk(`OFS_PORT_STATUS, '1, {fqual, 8'h01});
    $display("test port data finished");
    host.wr(`OFS_MAILBOX, `MB_MAC_LO);
    rdchk(`OFS_MAILBOX, '1, MAC[31:0]);
    host.wr(`OFS_MAILBOX, `MB_MAC_HI);
    rdchk(`OFS_MAILBOX, '1, {16'h0000, MAC[47:32]});
    for (int k = 0; k < 3; k++) begin
      host.wr(`OFS_MAILBOX, `MB_SER_0 - 32'(k));
      rdchk(`OFS_MAILBOX, '1, SERIAL[32*k +: 32]);
    end
    for (int k = 0; k < 2; k++) begin
      hist_idx = 8'(k * 255);
      hist_data = 32'h1000_0000 + 32'(k);
      pulse(6);
      host.wr(`OFS_MAILBOX, 32'hffff_fff8 - 32'(k * 255));
      rdchk(`OFS_MAILBOX, '1, hist_data);
    end
    host.wr(`OFS_MAILBOX, `MB_INVAL);
    chk(64'(nvm_inv), 64'h1);
    pulse(7);
    tick(1);
    rdchk(`OFS_MAILBOX, '1, 32'h0000_0000);
    host.wr(`OFS_MAILBOX, `MB_ERASE);
    tick(260);
    rdchk(`OFS_MAILBOX, '1, 32'h0000_0000);
    $display("test mailbox codes finished");
    host.wr(`OFS_MAILBOX, 32'h7fff_7fff);
    rdchk(`OFS_MAILBOX, '1, 32'h0fff_0fff);
    host.wr(`OFS_MAILBOX, 32'h0000_8a41);
    chk({cib, cid, cin}, {51'h0, 1'b1, 4'ha, 8'h41});
    pulse(5);
    chk(64'(cib), 64'h0);
    chr = 8'h5c;
    pulse(4);
    rdchk(`OFS_MAILBOX, '1, {4'h8, NODE_ID, 8'h5c, 16'h0a41});
    host.wr(`OFS_MAILBOX, 32'h0000_0000);
    rdchk(`OFS_MAILBOX, 32'h8000_0000, 32'h0000_0000);
    $display("test characters finished");
    ca_cmd = 4'h7;
    ca_len = 2'h2;
    ca_mask = 16'hbeef;
    ca_addr = 40'hc5_a123_4567;
    addr40 = 1'b1;
    more_req = 1'b1;
    pulse(0);
    chk(64'(ca_valid), 64'h1);
    chk(ca_data, exp_ca());
    more_en = 1'b1;
    pulse(0);
    chk(ca_data, exp_ca());
    e = exp_ca();
    rdchk(`OFS_FAIL_ADDR, '1, e[31:0]);
    rdchk(`OFS_FAIL_EXT, '1, {e[63:60], 2'b00, e[57:32]});
    pulse(1);
    ca_addr = 40'h00_2000_0123;
    addr40 = 1'b0;
    ca_cmd = 4'h2;
    ca_len = 2'h1;
    pulse(0);
    chk(ca_data, exp_ca());
    rdchk(`OFS_FAIL_ADDR, '1, e[31:0]);
    rdchk(`OFS_FAIL_EXT, '1, {e[63:60], 2'b00, e[57:32]});
    pulse(2);
    tick(1);
    pulse(0);
    e = exp_ca();
    rdchk(`OFS_FAIL_ADDR, '1, e[31:0]);
    dma_hi = 10'h2a5;
    dma_mask = 16'h1234;
    pulse(3);
    rdchk(`OFS_FAIL_EXT, '1, {e[63:60], 2'b00, dma_hi, dma_mask});
    $display("test failing log finished");
    end_sim();
  end
endmodule : bus_node_port_register_set_tb

// >>> sim/host_port_driver.sv
// Host-side model of the register port: one write or read strobe per call.
// Assumes callers enter each task just after a falling edge of clk_i.
`timescale 1ns/1ps

module host_port_driver (
  input wire logic clk_i,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [11:0] reg_addr_o,
  output logic [31:0] reg_wdata_o,
  input wire logic [31:0] reg_rdata_i,
  input wire logic reg_rvalid_i
);
  // ==========================================================
  // Idle bus
  // Quiet levels at time zero
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 12'h000;
    reg_wdata_o = 32'h0000_0000;
  end

  // ==========================================================
  // Accesses
  // Full-longword write; one idle edge first so back-to-back writes never
  // lower and raise the strobe in the same time step
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask : wr

  // Read strobe, then wait a bounded time for the answer
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    int n;
    n = 0;
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge clk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = 'x;
    while (reg_rvalid_i !== 1'b1 && n < 4) begin
      @(negedge clk_i);
      n++;
    end
    if (reg_rvalid_i === 1'b1) begin
      d = reg_rdata_i;
    end
  endtask : rd
endmodule : host_port_driver
